// ===== pkg/apdt_defines.vh
// Constants for the asynchronous parallel display access timing block.
// Assumes word addressing on the register bus and 32-bit register words.
`ifndef APDT_DEFINES_VH
`define APDT_DEFINES_VH

// ==========================================================
// Register word addresses
`define APDT_REG_FCLK 4'h0
`define APDT_REG_CONF1 4'h1
`define APDT_REG_CONF2 4'h2
`define APDT_REG_CONF3 4'h3
`define APDT_REG_POL 4'h4
`define APDT_REG_MODE 4'h5
`define APDT_REG_CMD 4'h6
`define APDT_REG_STATUS 4'h7
`define APDT_REG_RDATA 4'h8

// ==========================================================
// Field positions
`define APDT_CMD_DIR 16
`define APDT_CMD_RS 17
`define APDT_MODE_SINGLE 0
`define APDT_MODE_68K 1
`define APDT_POL_CS 0
`define APDT_POL_WR 1
`define APDT_POL_RD 2
`define APDT_POL_RS 3
`define APDT_ST_BUSY 0
`define APDT_ST_RVALID 1
`define APDT_ST_PEND 2

// ==========================================================
// Reset values
`define APDT_FCLK_RST 16'h0001
`define APDT_CONF1_RST 32'h0008_0008
`define APDT_CONF2_RST 32'h0604_0602
`define APDT_CONF3_RST 16'h0004
`define APDT_POL_RST 4'h0
`define APDT_MODE_RST 2'h0

// ==========================================================
// Timing: one clk cycle is one half step of the fast internal clock.
`define APDT_CLK_NS 20
`define APDT_HALF_PER_FAST 2

`endif

// ===== design/apdt_timing_gen.v
// Access timing generator for the asynchronous parallel display port.
// Assumes an Avalon-MM master on clk and a display panel on the pins.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "apdt_defines.vh"

module apdt_timing_gen #(
   parameter DW = 16
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Avalon-MM register slave
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output wire [31:0] avs_readdata,
   output wire avs_waitrequest,
   // Display panel pins
   output wire disp_cs,
   output wire disp_wr,
   output wire disp_rd,
   output wire disp_rs,
   output wire [DW-1:0] disp_bus_drive,
   output wire disp_bus_drive_en,
   input wire [DW-1:0] disp_bus_sample
);

   // ==========================================================
   // States
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_ACC = 2'b01;
   localparam [1:0] ST_GAP = 2'b10;

   // ==========================================================
   // Declarations
   reg [15:0] fclk_r;
   reg [15:0] rd_per_r;
   reg [15:0] wr_per_r;
   reg [7:0] wr_up_r;
   reg [7:0] wr_dn_r;
   reg [7:0] rd_up_r;
   reg [7:0] rd_dn_r;
   reg [15:0] rd_cap_r;
   reg [3:0] pol_r;
   reg [1:0] mode_r;
   reg wait_r;
   reg [31:0] rdata_bus_r;
   reg [31:0] rdata_mux;
   reg pend_v_r;
   reg pend_dir_r;
   reg pend_rs_r;
   reg [DW-1:0] pend_dat_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [17:0] acc_r;
   reg [17:0] acc_nxt;
   reg ph_r;
   reg ph_nxt;
   reg take;
   reg dir_r;
   reg rs_r;
   reg [DW-1:0] wdat_r;
   reg cap_done_r;
   reg [DW-1:0] rcap_r;
   reg rvalid_r;
   reg [DW-1:0] ds1_r;
   reg [DW-1:0] ds2_r;
   reg disp_cs_r;
   reg disp_wr_r;
   reg disp_rd_r;
   reg disp_rs_r;
   reg [DW-1:0] dout_r;
   reg dout_en_r;

   // ==========================================================
   // Bus decode
   wire req = avs_read | avs_write;
   wire is_cmd = (avs_address == `APDT_REG_CMD);
   // A command waits on the bus while one is already pending.
   wire can_take = ~(avs_write & is_cmd & pend_v_r);
   wire wr_fire = avs_write & ~wait_r;
   wire cmd_fire = wr_fire & is_cmd;

   // ==========================================================
   // Timing arithmetic: everything is compared in doubled units, so
   // ceilings of a quotient never need a divider.
   wire [16:0] per2 = {(dir_r ? rd_per_r : wr_per_r), 1'b0};
   wire [8:0] up2 = {(dir_r ? rd_up_r : wr_up_r), 1'b0};
   wire [8:0] dn2 = {(dir_r ? rd_dn_r : wr_dn_r), 1'b0};
   wire [16:0] cap2 = {rd_cap_r, 1'b0};
   wire [17:0] sum = acc_r + {2'b00, fclk_r};
   // Ends on a whole fast cycle, so the period rounds up.
   wire last = ph_r & (sum >= {1'b0, per2});
   // Half-step index h meets h*B >= 2*setting at the rounded-up instant.
   wire past_up = (acc_r >= {9'h000, up2});
   wire past_dn = (acc_r >= {9'h000, dn2});
   wire strobe = past_up & ~past_dn;
   wire in_acc = (state_r == ST_ACC);
   // Capture only on whole fast cycles.
   wire cap_hit = in_acc & dir_r & ~ph_r & ~cap_done_r & (acc_r >= {1'b0, cap2});

   // ==========================================================
   // Avalon handshake: one wait cycle, more for a command while one is pending, then a single answer cycle.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_r <= 1'b1;
      end else if (req & wait_r & can_take) begin
         wait_r <= 1'b0;
      end else begin
         wait_r <= 1'b1;
      end
   end

   always @* begin
      rdata_mux = 32'h0000_0000;
      case (avs_address)
         `APDT_REG_FCLK: rdata_mux = {16'h0000, fclk_r};
         `APDT_REG_CONF1: rdata_mux = {rd_per_r, wr_per_r};
         `APDT_REG_CONF2: rdata_mux = {rd_dn_r, rd_up_r, wr_dn_r, wr_up_r};
         `APDT_REG_CONF3: rdata_mux = {16'h0000, rd_cap_r};
         `APDT_REG_POL: rdata_mux = {28'h0000000, pol_r};
         `APDT_REG_MODE: rdata_mux = {30'h00000000, mode_r};
         `APDT_REG_STATUS: rdata_mux = {29'h00000000, pend_v_r, rvalid_r,
                                        (state_r != ST_IDLE)};
         `APDT_REG_RDATA: rdata_mux[DW-1:0] = rcap_r;
         default: rdata_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_bus_r <= 32'h0000_0000;
      end else if (avs_read & wait_r) begin
         rdata_bus_r <= rdata_mux;
      end
   end

   // ==========================================================
   // Timing configuration registers
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fclk_r <= `APDT_FCLK_RST;
         {rd_per_r, wr_per_r} <= `APDT_CONF1_RST;
         {rd_dn_r, rd_up_r, wr_dn_r, wr_up_r} <= `APDT_CONF2_RST;
         rd_cap_r <= `APDT_CONF3_RST;
         pol_r <= `APDT_POL_RST;
         mode_r <= `APDT_MODE_RST;
      end else if (wr_fire) begin
         case (avs_address)
            // A zero step would stall the accumulator forever.
            `APDT_REG_FCLK: fclk_r <= (avs_writedata[15:0] == 16'h0000) ?
                                      16'h0001 : avs_writedata[15:0];
            `APDT_REG_CONF1: begin
               rd_per_r <= avs_writedata[31:16];
               wr_per_r <= avs_writedata[15:0];
            end
            `APDT_REG_CONF2: begin
               rd_dn_r <= avs_writedata[31:24];
               rd_up_r <= avs_writedata[23:16];
               wr_dn_r <= avs_writedata[15:8];
               wr_up_r <= avs_writedata[7:0];
            end
            `APDT_REG_CONF3: rd_cap_r <= avs_writedata[15:0];
            `APDT_REG_POL: pol_r <= avs_writedata[3:0];
            `APDT_REG_MODE: mode_r <= avs_writedata[1:0];
            default: mode_r <= mode_r;
         endcase
      end
   end

   // ==========================================================
   // One-entry command hold so the next access can start without a
   // gap cycle when the previous one ends.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend_v_r <= 1'b0;
         pend_dir_r <= 1'b0;
         pend_rs_r <= 1'b0;
         pend_dat_r <= {DW{1'b0}};
      end else if (cmd_fire) begin
         pend_v_r <= 1'b1;
         pend_dir_r <= avs_writedata[`APDT_CMD_DIR];
         pend_rs_r <= avs_writedata[`APDT_CMD_RS];
         pend_dat_r <= avs_writedata[DW-1:0];
      end else if (take) begin
         pend_v_r <= 1'b0;
      end
   end

   // ==========================================================
   // Access sequencer
   always @* begin
      state_nxt = state_r;
      acc_nxt = sum;
      ph_nxt = ~ph_r;
      take = 1'b0;
      case (state_r)
         ST_IDLE: begin
            acc_nxt = 18'h00000;
            ph_nxt = 1'b0;
            if (pend_v_r) begin
               state_nxt = ST_ACC;
               take = 1'b1;
            end
         end
         ST_ACC: begin
            if (last) begin
               acc_nxt = 18'h00000;
               ph_nxt = 1'b0;
               if (mode_r[`APDT_MODE_SINGLE]) begin
                  state_nxt = ST_GAP;
               end else if (pend_v_r) begin
                  take = 1'b1;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_GAP: begin
            // Idle time lasts one interface period of the last access.
            if (last) begin
               acc_nxt = 18'h00000;
               ph_nxt = 1'b0;
               if (pend_v_r) begin
                  state_nxt = ST_ACC;
                  take = 1'b1;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            acc_nxt = 18'h00000;
            ph_nxt = 1'b0;
         end
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         acc_r <= 18'h00000;
         ph_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         ph_r <= ph_nxt;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dir_r <= 1'b0;
         rs_r <= 1'b0;
         wdat_r <= {DW{1'b0}};
      end else if (take) begin
         dir_r <= pend_dir_r;
         rs_r <= pend_rs_r;
         wdat_r <= pend_dat_r;
      end
   end

   // ==========================================================
   // Read data path: the panel must settle before the capture point,
   // so the synchroniser delay is part of the loopback budget.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ds1_r <= {DW{1'b0}};
         ds2_r <= {DW{1'b0}};
      end else begin
         ds1_r <= disp_bus_sample;
         ds2_r <= ds1_r;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cap_done_r <= 1'b0;
         rcap_r <= {DW{1'b0}};
      end else if (take) begin
         cap_done_r <= 1'b0;
      end else if (cap_hit) begin
         cap_done_r <= 1'b1;
         rcap_r <= ds2_r;
      end
   end

   // A capture in the same cycle as a software clear keeps the flag set.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rvalid_r <= 1'b0;
      end else if (cap_hit) begin
         rvalid_r <= 1'b1;
      end else if (wr_fire & (avs_address == `APDT_REG_STATUS) &
                   avs_writedata[`APDT_ST_RVALID]) begin
         rvalid_r <= 1'b0;
      end
   end

   // ==========================================================
   // Pin drivers. Logical active levels are mapped to pins through the
   // polarity bits; zero means active low.
   wire is68k = mode_r[`APDT_MODE_68K];
   wire rd_act = is68k ? (in_acc & strobe) : (in_acc & strobe & dir_r);
   wire wr_act = is68k ? (in_acc & dir_r) : (in_acc & strobe & ~dir_r);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         disp_cs_r <= 1'b1;
         disp_wr_r <= 1'b1;
         disp_rd_r <= 1'b1;
         disp_rs_r <= 1'b1;
         dout_r <= {DW{1'b0}};
         dout_en_r <= 1'b0;
      end else begin
         disp_cs_r <= ~(in_acc ^ pol_r[`APDT_POL_CS]);
         disp_wr_r <= ~(wr_act ^ pol_r[`APDT_POL_WR]);
         disp_rd_r <= ~(rd_act ^ pol_r[`APDT_POL_RD]);
         disp_rs_r <= ~((in_acc & rs_r) ^ pol_r[`APDT_POL_RS]);
         dout_r <= wdat_r;
         dout_en_r <= in_acc & ~dir_r;
      end
   end

   // ==========================================================
   // Outputs
   assign avs_readdata = rdata_bus_r;
   assign avs_waitrequest = wait_r;
   assign disp_cs = disp_cs_r;
   assign disp_wr = disp_wr_r;
   assign disp_rd = disp_rd_r;
   assign disp_rs = disp_rs_r;
   assign disp_bus_drive = dout_r;
   assign disp_bus_drive_en = dout_en_r;

endmodule // apdt_timing_gen
`default_nettype wire

// ===== testbench/apdt_chk_assertions.sv
// Checker: bus answers, strobe nesting and strobe widths.
// Assumes the top ports only; it shadows settings from bus writes.
`timescale 1ns/100ps
`default_nettype none
`include "apdt_defines.vh"
module apdt_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register bus
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Panel pins
   input wire logic disp_cs,
   input wire logic disp_wr,
   input wire logic disp_rd,
   input wire logic disp_bus_drive_en
);
   logic [15:0] fclk_r;
   logic [31:0] tm_r;
   logic [3:0] pol_r, pold_r;
   logic m68_r, quiet, cs_on, wr_on, rd_on;
   int wcnt_r, rcnt_r, wlen, rlen;
   function automatic int ce(input int n, input int d);
      return (n + d - 1) / d;
   endfunction
   always_comb begin
      wlen = ce(2 * tm_r[15:8], fclk_r) - ce(2 * tm_r[7:0], fclk_r);
      rlen = ce(2 * tm_r[31:24], fclk_r) - ce(2 * tm_r[23:16], fclk_r);
      // Pins take a new polarity a cycle late, and 68k pins mean other things.
      quiet = pold_r != pol_r || m68_r;
      cs_on = disp_cs == pol_r[0];
      wr_on = disp_wr == pol_r[1];
      rd_on = disp_rd == pol_r[2];
   end
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fclk_r <= `APDT_FCLK_RST;
         tm_r <= `APDT_CONF2_RST;
         pol_r <= `APDT_POL_RST;
         pold_r <= `APDT_POL_RST;
         m68_r <= 1'b0;
         wcnt_r <= 0;
         rcnt_r <= 0;
      end else begin
         if (avs_write && !avs_waitrequest) begin
            case (avs_address)
               `APDT_REG_FCLK: fclk_r <= avs_writedata[15:0];
               `APDT_REG_CONF2: tm_r <= avs_writedata;
               `APDT_REG_POL: pol_r <= avs_writedata[3:0];
               `APDT_REG_MODE: m68_r <= avs_writedata[`APDT_MODE_68K];
               default: ;
            endcase
         end
         pold_r <= pol_r;
         wcnt_r <= wr_on ? wcnt_r + 1 : 0;
         rcnt_r <= rd_on ? rcnt_r + 1 : 0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   sequence s_wr_end;
      $fell(wr_on) && !quiet && !$past(quiet);
   endsequence
   sequence s_rd_end;
      $fell(rd_on) && !quiet && !$past(quiet);
   endsequence
   a_read_one_wait: assert property (avs_read && avs_waitrequest |=> s_answer)
      else $error("late read answer");
   a_cmd_taken_bound: assert property (
      avs_write && avs_waitrequest && avs_address == `APDT_REG_CMD |-> ##[1:100] !avs_waitrequest)
      else $error("command never taken");
   a_unmapped_zero: assert property (
      avs_read && !avs_waitrequest && avs_address > `APDT_REG_RDATA |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_reset_idle: assert property (
      $rose(nrst) |-> disp_cs && disp_wr && disp_rd && !disp_bus_drive_en)
      else $error("pins not idle after reset");
   a_strobe_in_cs: assert property (!quiet && (wr_on || rd_on) |-> cs_on)
      else $error("strobe outside select");
   a_rd_wr_apart: assert property (!quiet |-> !(wr_on && rd_on))
      else $error("both strobes active");
   a_wr_width: assert property (s_wr_end |-> wcnt_r == wlen)
      else $error("write strobe width wrong");
   a_rd_width: assert property (s_rd_end |-> rcnt_r == rlen)
      else $error("read strobe width wrong");
endmodule // apdt_chk
bind apdt_timing_gen apdt_chk u_apdt_chk (
   .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .disp_cs(disp_cs), .disp_wr(disp_wr),
   .disp_rd(disp_rd), .disp_bus_drive_en(disp_bus_drive_en));
`default_nettype wire

// ===== testbench/apdt_panel.sv
// Panel model: returns read data while read strobed, promptly or a cycle late.
// Assumes the bench tells it the pin polarity and the bus style.
`timescale 1ns/100ps
`default_nettype none
module apdt_panel (
   // Pins
   input wire logic clk,
   input wire logic disp_cs,
   input wire logic disp_wr,
   input wire logic disp_rd,
   output var logic [15:0] disp_bus_sample,
   // Bench control
   input wire logic [3:0] pol,
   input wire logic m68k,
   input wire logic slow,
   input wire logic [15:0] rdat
);
   logic rd_on, late_r;
   // In 68k style the read pin enables and an active write pin means read.
   assign rd_on = disp_rd == pol[2] && (!m68k || disp_wr == pol[1]);
   initial disp_bus_sample = 16'h0000;
   always @(posedge clk) begin
      late_r <= rd_on;
      if (rd_on && (!slow || late_r)) begin
         disp_bus_sample <= rdat;
      end else if (disp_cs != pol[0]) begin
         // A released bus must not hold a value that could pass for data.
         disp_bus_sample <= ~disp_bus_sample;
      end
   end
endmodule // apdt_panel
`default_nettype wire

// ===== testbench/apdt_timing_gen_bench.sv
// Bench for the display access timing block: random settings, writes, reads.
// Assumes the panel model on the pins and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`include "apdt_defines.vh"
module apdt_timing_gen_bench;
   logic clk, nrst, avs_read, avs_write, avs_waitrequest, disp_cs, disp_wr, disp_rd, disp_rs;
   logic disp_bus_drive_en, m68k, slow, wr_dir, cs_on, st_on, clr, rsb;
   logic [3:0] avs_address, pol, pn;
   logic [31:0] avs_writedata, avs_readdata, rq;
   logic [15:0] disp_bus_drive, disp_bus_sample, rdat, wdat;
   logic [31:0] rst_v [0:5] = '{32'(`APDT_FCLK_RST), `APDT_CONF1_RST, `APDT_CONF2_RST,
      32'(`APDT_CONF3_RST), 32'(`APDT_POL_RST), 32'(`APDT_MODE_RST)};
   int fail_count, num_checks, tgt, m_a, m_g, m_u, m_s, m_bad, sb, sp, su, sd, sm;
   apdt_timing_gen u_apdt_timing_gen (.clk(clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .disp_cs(disp_cs),
      .disp_wr(disp_wr), .disp_rd(disp_rd), .disp_rs(disp_rs), .disp_bus_drive(disp_bus_drive),
      .disp_bus_drive_en(disp_bus_drive_en), .disp_bus_sample(disp_bus_sample));
   apdt_panel u_apdt_panel (.clk(clk), .disp_cs(disp_cs), .disp_wr(disp_wr), .disp_rd(disp_rd),
      .disp_bus_sample(disp_bus_sample), .pol(pol), .m68k(m68k), .slow(slow), .rdat(rdat));
   assign cs_on = disp_cs === pol[0];
   assign st_on = (m68k || !wr_dir) ? disp_rd === pol[2] : disp_wr === pol[1];
   // Counters are cleared here only, so a clear never races a count on the same edge.
   always @(posedge clk) begin
      if (clr) begin
         {m_a, m_g, m_u, m_s, m_bad} <= '0;
      end else begin
         if (cs_on) m_a <= m_a + 1;
         else if (m_a > 0 && m_a < tgt) m_g <= m_g + 1;
         if (st_on) m_s <= m_s + 1;
         if (cs_on && !st_on && m_s == 0) m_u <= m_u + 1;
         if (st_on && wr_dir && {disp_bus_drive_en, disp_bus_drive} !== {1'b1, wdat}) m_bad <= 1;
         if (cs_on && disp_rs !== (rsb ~^ pol[3])) m_bad <= 1;
      end
   end
   function automatic int ce(input int n, input int d);
      return (n + d - 1) / d;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 200);
      if (n >= 200) fail_count++;
      rq = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic access(input logic w, input int n);
      int len;
      len = 2 * ce(w ? sp : sp + sb, sb);
      wr_dir = w;
      wdat = 16'($urandom);
      rsb = 1'($urandom);
      tgt = n * len;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) bus(1'b1, `APDT_REG_CMD, {14'h0, rsb, !w, wdat});
      for (int k = 0; k < 300 && m_a < tgt; k++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk(m_a, tgt);
      chk(m_g, (n - 1) * len * sm[0]);
      chk(m_u, ce(2 * su, sb));
      chk(m_s, n * (ce(2 * sd, sb) - ce(2 * su, sb)));
      chk(m_bad, 0);
   endtask
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #400000;
      fail_count++;
      print_verdict;
   end
   initial begin
      {nrst, avs_read, avs_write, m68k, slow, wr_dir, avs_address, pol, clr, rsb} = '0;
      {avs_writedata, rdat, wdat, fail_count, num_checks, tgt} = '0;
      {m_a, m_g, m_u, m_s, m_bad} = '0;
      rq = $urandom(32'hFF620E8E);
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      foreach (rst_v[i]) begin
         bus(1'b0, 4'(i), 32'h0);
         chk(rq, rst_v[i]);
      end
      bus(1'b1, 4'hC, 32'hFFFFFFFF);
      bus(1'b0, 4'hC, 32'h0);
      chk(rq, 32'h0);
      for (int i = 0; i < 8; i++) begin
         sb = 1 + $urandom % 3;
         su = $urandom % 6;
         sd = su + sb + $urandom % 4;
         // Capture well after the strobe leaves room for pins, panel and synchroniser.
         sp = (sd > su + 4 * sb ? sd : su + 4 * sb) + sb + $urandom % 3;
         sm = i % 4;
         pn = (i < 2) ? 4'h0 : 4'($urandom);
         bus(1'b1, `APDT_REG_FCLK, 32'(sb));
         bus(1'b1, `APDT_REG_CONF1, {16'(sp + sb), 16'(sp)});
         bus(1'b1, `APDT_REG_CONF2, {8'(sd), 8'(su), 8'(sd), 8'(su)});
         bus(1'b1, `APDT_REG_CONF3, 32'(su + 4 * sb));
         bus(1'b1, `APDT_REG_POL, {28'h0, pn});
         bus(1'b1, `APDT_REG_MODE, 32'(sm));
         bus(1'b0, `APDT_REG_CONF2, 32'h0);
         chk(rq, {8'(sd), 8'(su), 8'(sd), 8'(su)});
         pol <= pn;
         m68k <= sm[1];
         slow <= i[2];
         rdat <= 16'($urandom);
         access(1'b1, 2);
         access(1'b0, 2);
         bus(1'b0, `APDT_REG_RDATA, 32'h0);
         chk(rq, {16'h0, rdat});
         // Single mode is still in its idle gap here; read valid was cleared last round.
         bus(1'b0, `APDT_REG_STATUS, 32'h0);
         chk(rq, {29'h0, 1'b0, 1'b1, sm[0]});
         bus(1'b1, `APDT_REG_STATUS, 32'h2);
         $display("test %0d done", i);
      end
      print_verdict;
   end
endmodule // apdt_timing_gen_bench
`default_nettype wire
